// ===== hw/chan_sel_if.sv
`timescale 1ns/1ps
interface chan_sel_if;
    logic selWrite;
    logic [7:0] selData;
    logic [io_chain_pkg::CHAN_W-1:0] ownChannel;
    logic shutdown;
    io_chain_pkg::link_state_t linkState;
    modport ctrl (output selWrite, output selData, output ownChannel,
        output shutdown, input linkState);
    modport sel (input selWrite, input selData, input ownChannel,
        input shutdown, output linkState);
endinterface : chan_sel_if

// ===== hw/channel_connect.sv
`timescale 1ns/1ps
module channel_connect (
    input wire logic ref_clk,
    input wire logic rst,
    chan_sel_if.sel bus
);
    io_chain_pkg::link_state_t state;
    io_chain_pkg::link_state_t next_state;

    // Next connection state from each selection write
    always_comb begin
        next_state = state;
        if (bus.shutdown) begin
            next_state = io_chain_pkg::LINK_IDLE;
        end else if (bus.selWrite) begin
            if (bus.selData == io_chain_pkg::BROADCAST_CMD) begin
                next_state = io_chain_pkg::LINK_BROADCAST;
            end else if (bus.selData == {5'h00, bus.ownChannel}) begin
                next_state = io_chain_pkg::LINK_SELECTED;
            end else begin
                next_state = io_chain_pkg::LINK_IDLE;
            end
        end
    end

    // Connection register, disconnected after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= io_chain_pkg::LINK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign bus.linkState = state;
endmodule : channel_connect

// ===== hw/io_chain_channel_transmitter.sv
// Functional notes
// - Status byte: channel number, card present
// - Bits 4,5 zero; trap enable, fault bits
// - No answer means input table untouched
// - Matching value at 127 connects channel
// - Other value at 127 disconnects channel
// - 80H connects all, no input data
// - Normal one chain; multi_channel_mode up to eight
// - Channel from first three switches only
// - Bad isolated supply shuts down; lamp
// - Chain ok lamp: power and continuity
// - Chain parity lamp: downstream parity good
// - Fault enable lamp shows stop jumper
// - Jumpers: fault stop, chain mode
`timescale 1ns/1ps
module io_chain_channel_transmitter (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic outWrite,
    input wire logic [6:0] outAddr,
    input wire logic [7:0] outData,
    input wire logic inRead,
    input wire logic [6:0] inAddr,
    input wire logic [2:0] inChannel,
    input wire logic [2:0] channelSwitch,
    input wire logic local_fault_stop_jumper,
    input wire logic chain_mode_jumper,
    input wire logic localFault,
    input wire logic isoSupplyOk,
    input wire logic stationPowerOk,
    input wire logic cableContinuity,
    input wire logic downstreamParityOk,
    output logic statusValid,
    output logic [7:0] channel_status_byte,
    output logic chainConnected,
    output logic faultStop,
    output logic isoPowerLamp,
    output logic chainOkLamp,
    output logic chainParityLamp,
    output logic faultEnableLamp,
    output logic chainActiveLamp
);
    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // True when a scan address names the selection byte
    function automatic logic is_sel_addr(
        input logic [6:0] addr
    );
        return addr == io_chain_pkg::SEL_ADDR;
    endfunction : is_sel_addr

    // Status answer for one channel with its fixed bits filled in
    function automatic logic [7:0] build_status(
        input logic [io_chain_pkg::CHAN_W-1:0] chan,
        input logic trapEnable,
        input logic faultNow
    );
        logic [7:0] value;
        value = io_chain_pkg::STATUS_RESET;
        value[io_chain_pkg::ST_CHAN_LSB +: io_chain_pkg::CHAN_W]
            = chan;
        value[io_chain_pkg::ST_PRESENT] = 1'b1;
        value[io_chain_pkg::ST_ZERO_LSB +: 2] = 2'h0;
        value[io_chain_pkg::ST_TRAP_EN] = trapEnable;
        value[io_chain_pkg::ST_FAULT] = faultNow;
        return value;
    endfunction : build_status

    // ------------------------------------------------------------
    // Supply monitor
    // ------------------------------------------------------------
    logic supplyGood;

    // Link, status answers and active lamp are shut down while the isolated supply is bad
    assign supplyGood = isoSupplyOk;

    // ------------------------------------------------------------
    // Scan decode
    // ------------------------------------------------------------
    logic selWriteSeen;
    logic selReadSeen;

    // Writes and reads that name the selection byte
    assign selWriteSeen = outWrite && is_sel_addr(outAddr);
    assign selReadSeen = inRead && is_sel_addr(inAddr);

    // ------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------
    chan_sel_if selBus ();
    logic multi_channel_mode;

    // Mode from jumper; normal mode has one fixed channel
    assign multi_channel_mode = chain_mode_jumper;
    assign selBus.ownChannel = multi_channel_mode ? channelSwitch
        : io_chain_pkg::NORMAL_CHANNEL;

    // Only writes to the selection byte reach the tracker
    assign selBus.selWrite = selWriteSeen;

    // Selection data and shutdown pass straight to the tracker
    assign selBus.selData = outData;
    assign selBus.shutdown = !supplyGood;

    // Connection tracker, idle after reset
    channel_connect selector (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus(selBus.sel)
    );

    // ------------------------------------------------------------
    // Connection view
    // ------------------------------------------------------------
    logic selected;
    logic connected;

    // Broadcast connects the chain but does not answer reads
    assign connected = selBus.linkState != io_chain_pkg::LINK_IDLE;

    // Reads are answered only in the selected state
    assign selected = selBus.linkState == io_chain_pkg::LINK_SELECTED;

    // ------------------------------------------------------------
    // Status answer
    // ------------------------------------------------------------
    logic statusAsked;
    logic next_statusValid;
    logic [7:0] next_status;

    // A read of this channel's byte while selected and powered
    assign statusAsked = selReadSeen && selected
        && inChannel == selBus.ownChannel && supplyGood;

    // Status byte built on a read; otherwise the old byte stays
    always_comb begin
        next_statusValid = 1'b0;
        next_status = channel_status_byte;
        if (statusAsked) begin
            next_statusValid = 1'b1;
            next_status = build_status(selBus.ownChannel,
                local_fault_stop_jumper,
                localFault);
        end
    end

    // Answer registers; the valid flag stands for one cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            statusValid <= 1'b0;
            channel_status_byte <= io_chain_pkg::STATUS_RESET;
        end else begin
            statusValid <= next_statusValid;
            channel_status_byte <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Chain connection and fault stop
    // ------------------------------------------------------------
    logic next_chainConnected;
    logic next_faultStop;

    // Joined only while connected and the supply is good
    always_comb begin
        next_chainConnected = connected && supplyGood;
        next_faultStop = localFault && local_fault_stop_jumper;
    end

    // Connection and stop registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chainConnected <= 1'b0;
            faultStop <= 1'b0;
        end else begin
            chainConnected <= next_chainConnected;
            faultStop <= next_faultStop;
        end
    end

    // ------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------
    logic next_isoPowerLamp;
    logic next_chainOkLamp;
    logic next_chainParityLamp;
    logic next_faultEnableLamp;
    logic next_chainActiveLamp;

    // Lamp values follow their inputs one clock later
    always_comb begin
        next_isoPowerLamp = supplyGood;
        next_chainOkLamp = stationPowerOk
            && cableContinuity;
        next_chainParityLamp = downstreamParityOk;
        next_faultEnableLamp = local_fault_stop_jumper;
        next_chainActiveLamp = multi_channel_mode && connected
            && supplyGood;
    end

    // Lamp registers, all dark during reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            isoPowerLamp <= 1'b0;
            chainOkLamp <= 1'b0;
            chainParityLamp <= 1'b0;
            faultEnableLamp <= 1'b0;
            chainActiveLamp <= 1'b0;
        end else begin
            isoPowerLamp <= next_isoPowerLamp;
            chainOkLamp <= next_chainOkLamp;
            chainParityLamp <= next_chainParityLamp;
            faultEnableLamp <= next_faultEnableLamp;
            chainActiveLamp <= next_chainActiveLamp;
        end
    end
endmodule : io_chain_channel_transmitter

// ===== hw/io_chain_pkg.sv
package io_chain_pkg;
    // ------------------------------------------------------------
    // Scan addresses and commands
    // ------------------------------------------------------------
    localparam logic [6:0] SEL_ADDR = 7'h7F; // Output/input byte 127
    localparam logic [7:0] BROADCAST_CMD = 8'h80;
    localparam int CHAN_W = 3;
    // ------------------------------------------------------------
    // channel_status_byte field positions
    // ------------------------------------------------------------
    localparam int ST_CHAN_LSB = 0;
    localparam int ST_PRESENT = 3;
    localparam int ST_ZERO_LSB = 4;
    localparam int ST_TRAP_EN = 6;
    localparam int ST_FAULT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [CHAN_W-1:0] NORMAL_CHANNEL = 3'h0;
    // ------------------------------------------------------------
    // Connection states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_SELECTED,
        LINK_BROADCAST
    } link_state_t;
endpackage : io_chain_pkg

// ===== test/cpu_scan.sv
`timescale 1ns/1ps
// CPU scan side: selection writes and status reads
module cpu_scan (
    input wire logic ref_clk,
    output logic outWrite = 0,
    output logic [6:0] outAddr = 0,
    output logic [7:0] outData = 0,
    output logic inRead = 0,
    output logic [6:0] inAddr = 0,
    output logic [2:0] inChannel = 0
);
    // One write strobe, then the released bus shows junk
    task wr(input logic [7:0] d);
        @(negedge ref_clk);
        {outWrite, outAddr, outData} <= {1'b1, 7'h7F, d};
        @(negedge ref_clk);
        {outWrite, outAddr, outData} <= {1'b0, 7'h00, ~d};
    endtask : wr
    // Scans a channel whether or not it answers
    task rd(input logic [2:0] c);
        @(negedge ref_clk);
        {inRead, inAddr, inChannel} <= {1'b1, 7'h7F, c};
        @(negedge ref_clk);
        {inRead, inAddr, inChannel} <= {1'b0, 7'h00, ~c};
    endtask : rd
endmodule : cpu_scan

// ===== test/io_chain_channel_transmitter_test.sv
`timescale 1ns/1ps
module io_chain_channel_transmitter_test;
    logic ref_clk = 0, rst = 1, local_fault_stop_jumper = 0, localFault = 0;
    logic chain_mode_jumper = 0, isoSupplyOk = 1, stationPowerOk = 0;
    logic cableContinuity = 0, downstreamParityOk = 0, outWrite, inRead;
    logic [2:0] channelSwitch = 0, inChannel, own;
    logic [6:0] outAddr, inAddr;
    logic [7:0] outData, channel_status_byte;
    logic statusValid, chainConnected, faultStop, isoPowerLamp, chainOkLamp;
    logic chainParityLamp, faultEnableLamp, chainActiveLamp;
    int fail_count = 0, check_count = 0;
    cpu_scan cpu (.*);
    io_chain_channel_transmitter uut (.*);
    // Clock
    initial forever #10 ref_clk = ~ref_clk;
    task go(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : go
    task ck(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : ck
    task results;
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    function logic [7:0] st(input logic [2:0] c, input logic j, input logic f);
        return {f, j, 3'h1, c};
    endfunction : st
    // Main sequence
    initial begin
        void'($urandom(32'h9D3A));
        go(8);
        rst = 0;
        repeat (12) begin
            {channelSwitch, local_fault_stop_jumper, chain_mode_jumper,
                localFault, stationPowerOk, cableContinuity,
                downstreamParityOk} = 9'($urandom);
            own = chain_mode_jumper ? channelSwitch : 3'h0;
            cpu.wr({5'h00, own});
            go(2);
            ck({2'h0, chainOkLamp, chainParityLamp, faultEnableLamp,
                isoPowerLamp, chainActiveLamp, chainConnected},
                {2'h0, stationPowerOk && cableContinuity,
                downstreamParityOk, local_fault_stop_jumper, 1'b1,
                chain_mode_jumper, 1'b1});
            cpu.rd(own);
            ck({statusValid, 7'h00}, 8'h80);
            ck(channel_status_byte,
                st(own, local_fault_stop_jumper, localFault));
            cpu.rd(own + 3'h1);
            ck({statusValid, 7'h00}, 8'h00);
            ck(channel_status_byte,
                st(own, local_fault_stop_jumper, localFault));
            cpu.wr(8'h80);
            go(2);
            ck({chainConnected, 7'h00}, 8'h80);
            cpu.rd(own);
            ck({statusValid, 7'h00}, 8'h00);
            cpu.wr(8'h81);
            go(2);
            ck({chainConnected, 7'h00}, 8'h00);
            cpu.wr({5'h00, own});
            isoSupplyOk = 0;
            go(3);
            ck({chainConnected, 7'h00}, 8'h00);
            isoSupplyOk = 1;
            go(2);
            ck({chainConnected, 7'h00}, 8'h00);
        end
        cpu.wr(8'h80);
        rst = 1;
        go(2);
        rst = 0;
        go(2);
        ck({chainConnected, 7'h00}, 8'h00);
        results;
    end
    // Watchdog
    initial begin
        #100us;
        fail_count++;
        results;
    end
endmodule : io_chain_channel_transmitter_test

// ===== test/io_chain_monitor.sv
`timescale 1ns/1ps
// ----
// Connection and status checks
// ----
module io_chain_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic outWrite,
    input wire logic [6:0] outAddr,
    input wire logic [7:0] outData,
    input wire logic inRead,
    input wire logic isoSupplyOk,
    input wire logic localFault,
    input wire logic local_fault_stop_jumper,
    input wire logic statusValid,
    input wire logic [7:0] channel_status_byte,
    input wire logic chainConnected,
    input wire logic faultStop,
    input wire logic isoPowerLamp,
    input wire logic faultEnableLamp
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Accepted write to the selection byte
    sequence selw;
        outWrite && outAddr == 7'h7F && isoSupplyOk;
    endsequence
    a_status_fixed: assert property (
        statusValid |-> channel_status_byte[5:3] == 3'h1) else $error("bad");
    a_status_fault: assert property (
        statusValid |-> channel_status_byte[7] == $past(localFault))
        else $error("fault bit");
    a_answer_cause: assert property (
        statusValid |-> $past(inRead)) else $error("answer unasked");
    a_byte_held: assert property (
        !statusValid |-> $stable(channel_status_byte)) else $error("byte");
    a_bcast_join: assert property (
        selw ##0 outData == 8'h80 |-> ##2 chainConnected) else $error("bc");
    a_foreign_drop: assert property (
        selw ##0 (outData[7] && outData != 8'h80) |-> ##2 !chainConnected)
        else $error("no drop");
    a_supply_drop: assert property (
        !isoSupplyOk |-> ##2 !chainConnected) else $error("supply");
    a_iso_lamp: assert property (
        !$past(rst) |-> isoPowerLamp == $past(isoSupplyOk)) else $error("iso");
    a_stop_lamp: assert property (
        !$past(rst) |-> faultEnableLamp == $past(local_fault_stop_jumper)
        && faultStop == $past(localFault && local_fault_stop_jumper))
        else $error("stop");
    a_join_cause: assert property (
        $rose(chainConnected) |-> $past(outWrite, 2)) else $error("join");
endmodule : io_chain_monitor
bind io_chain_channel_transmitter io_chain_monitor mon (.*);
